// *** rtl/ccrc_pkg.sv ***
/*
  Shared constants and types of the codec control register bank:
  register offsets, reset values, write masks, serial frame layouts,
  calibration length and the packed carriers of the control fields.
  Assumes a single 200 MHz system clock for all users.
*/
package ccrc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int unsigned NUM_REGS = 5;
  localparam logic [4:0] ADDR_INPUT_SELECTION = 5'h00;
  localparam logic [4:0] ADDR_BLOCK_POWER_CONTROL = 5'h01;
  localparam logic [4:0] ADDR_MIXING_FILTER_FORMAT = 5'h02;
  localparam logic [4:0] ADDR_INPUT_GAIN = 5'h03;
  localparam logic [4:0] ADDR_OUTPUT_GAIN = 5'h04;
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET =
    {8'h00, 8'h00, 8'h34, 8'h0f, 8'h05};
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK =
    {8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f};
  localparam logic [3:0] POWER_ALL_OFF = 4'h0;
  localparam int unsigned ZC_ENABLE_BIT = 7;

  // ****************************************************
  // Timing in frame-clock periods
  // ****************************************************
  localparam int unsigned CAL_FRAMES = 4128;
  localparam logic [11:0] TIMEOUT_BASE = 12'h100;

  // ****************************************************
  // Serial frame layouts
  // ****************************************************
  localparam int unsigned TW3_BITS = 16;
  localparam int unsigned TW3_ADDR_LSB = 3;
  localparam int unsigned TW3_DATA_LSB = 8;
  localparam int unsigned TW2_BITS = 11;
  localparam int unsigned TW2_DATA_LSB = 3;
  localparam int unsigned TW2_CMD_BIT = 0;
  localparam logic [3:0] TW2_LAST = 4'ha;

  typedef enum logic [1:0] {
    TW2_IDLE  = 2'b00,
    TW2_SHIFT = 2'b01,
    TW2_APPLY = 2'b10
  } ccrc_tw2_state_type;

  typedef struct packed {
    logic       right_input_two_on;
    logic       right_input_one_on;
    logic       left_input_two_on;
    logic       left_input_one_on;
    logic       output_gain_power;
    logic       dac_power;
    logic       adc_power;
    logic       input_stage_power;
    logic [1:0] mono_mix_select;
    logic [1:0] zero_cross_timeout;
    logic [1:0] deemphasis_select;
    logic [1:0] audio_format_select;
  } ccrc_ctrl_type;

  // Index 0 input left, 1 input right, 2 output left, 3 output right
  typedef struct packed {
    logic [3:0][6:0] code;
  } ccrc_gain_type;

endpackage

// *** rtl/ccrc_regs.sv ***
/*
  Codec control register bank with 3-wire and 2-wire serial write
  ports, power-down handling, offset calibration sequencing and
  zero-crossing gain update per channel.
  Assumes pins arrive asynchronously; the 3-wire clock is its own
  domain and stands still while select is high.
*/
// Summary of operation
// - Power-down pin low loads every register with its default.
// - Writes are ignored while the power-down pin is low.
// - Pin rising starts calibration lasting 4128 frame-clock periods.
// - ADC output words forced to zero during calibration.
// - Input and output gain stages held muted during calibration.
// - Calibration result kept when blocks are powered down by bits.
// - 3-wire frame: 3-bit opcode, 5-bit address, 8-bit data, LSB first.
// - 3-wire bits change on falling clock, sampled on rising edge.
// - 3-wire write commits at rising edge of select.
// - Writes to addresses above 04H are discarded.
// - 2-wire transfer: 3 info bits then 8 data bits, LSB first.
// - 2-wire bits driven on rising clock, latched on falling edge.
// - 2-wire byte applied at next rising clock after last data bit.
// - Four input enables; reset turns on first left and right only.
// - Power bits 0..3: input stage, ADC, DAC, output gain; reset 1.
// - All power bits zero or pin low powers down whole device.
// - Mono mix: stereo, average, left on both, right on both.
// - Zero-cross timeout 256, 512, 1024, 2048 frames; reset code 11.
// - De-emphasis: 44.1 kHz, off, 48 kHz, 32 kHz; reset off.
// - Audio format: 20, 16, 24-bit right justified or I2S; reset 00.
// - Input gain: bit 7 zero-cross enable, 7-bit code, resets mute.
// - Output gain: bit 7 zero-cross enable, codes above 39H unused.
// - Zero-cross enabled: apply per channel at crossing or timeout.
module ccrc_regs #(
  parameter int unsigned CAL_FRAMES = ccrc_pkg::CAL_FRAMES
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_chip_powerdown_pin_n,
  input  wire logic               i_frame_clock,
  input  wire logic               i_two_wire_mode,
  input  wire logic               i_three_wire_clock,
  input  wire logic               i_three_wire_select_low,
  input  wire logic               i_three_wire_data,
  input  wire logic               i_two_wire_clock,
  input  wire logic               i_two_wire_data,
  input  wire logic [3:0]         i_zero_cross,
  output ccrc_pkg::ccrc_ctrl_type o_ctrl,
  output ccrc_pkg::ccrc_gain_type o_gain,
  output logic                    o_calibrating,
  output logic                    o_cal_valid,
  output logic                    o_adc_force_zero,
  output logic                    o_device_powerdown
);

  localparam logic [12:0] CAL_LAST = 13'(CAL_FRAMES - 1);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [7:0] sync_m;
  logic [7:0] sync_s;
  logic [3:0] zc_m;
  logic [3:0] zc_s;
  logic       pdn_q;
  logic       frame_q;
  logic       sel_q;
  logic       tw2_clk_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      // Select idles high, so no false commit edge follows reset
      sync_m <= 8'h10;
      sync_s <= 8'h10;
      zc_m   <= 4'h0;
      zc_s   <= 4'h0;
    end else begin
      sync_m <= {i_chip_powerdown_pin_n, i_frame_clock, i_two_wire_mode,
                 i_three_wire_select_low, i_two_wire_clock, i_two_wire_data,
                 2'b00};
      sync_s <= sync_m;
      zc_m   <= i_zero_cross;
      zc_s   <= zc_m;
    end
  end

  logic pdn_s;
  logic frame_s;
  logic mode2_s;
  logic sel_s;
  logic tw2_clk_s;
  logic tw2_dat_s;
  assign pdn_s     = sync_s[7];
  assign frame_s   = sync_s[6];
  assign mode2_s   = sync_s[5];
  assign sel_s     = sync_s[4];
  assign tw2_clk_s = sync_s[3];
  assign tw2_dat_s = sync_s[2];

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pdn_q     <= 1'b0;
      frame_q   <= 1'b0;
      sel_q     <= 1'b1;
      tw2_clk_q <= 1'b0;
    end else begin
      pdn_q     <= pdn_s;
      frame_q   <= frame_s;
      sel_q     <= sel_s;
      tw2_clk_q <= tw2_clk_s;
    end
  end

  logic pdn_rise;
  logic frame_rise;
  logic sel_rise;
  logic tw2_fall;
  logic tw2_rise;
  assign pdn_rise   = pdn_s & ~pdn_q;
  assign frame_rise = frame_s & ~frame_q;
  assign sel_rise   = sel_s & ~sel_q;
  assign tw2_fall   = ~tw2_clk_s & tw2_clk_q;
  assign tw2_rise   = tw2_clk_s & ~tw2_clk_q;

  // ****************************************************
  // 3-wire shift register, link clock domain
  // ****************************************************
  logic [ccrc_pkg::TW3_BITS-1:0] link_shift;

  always_ff @(posedge i_three_wire_clock) begin
    if (!i_three_wire_select_low) begin
      link_shift <= {i_three_wire_data, link_shift[ccrc_pkg::TW3_BITS-1:1]};
    end
  end

  // Shift word is stable once select is high: no clock edges then
  logic       tw3_wr;
  logic [4:0] tw3_addr;
  logic [7:0] tw3_data;
  assign tw3_wr   = sel_rise & ~mode2_s;
  assign tw3_addr = link_shift[ccrc_pkg::TW3_ADDR_LSB +: 5];
  assign tw3_data = link_shift[ccrc_pkg::TW3_DATA_LSB +: 8];

  // ****************************************************
  // 2-wire receiver
  // ****************************************************
  ccrc_pkg::ccrc_tw2_state_type tw2_state;
  logic [ccrc_pkg::TW2_BITS-1:0] tw2_shift;
  logic [3:0]                    tw2_cnt;
  logic [4:0]                    tw2_ptr;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !mode2_s) begin
      tw2_state <= ccrc_pkg::TW2_IDLE;
      tw2_shift <= '0;
      tw2_cnt   <= 4'h0;
    end else begin
      unique case (tw2_state)
        ccrc_pkg::TW2_IDLE: begin
          if (tw2_fall && tw2_dat_s) begin
            tw2_state <= ccrc_pkg::TW2_SHIFT;
            tw2_cnt   <= 4'h0;
          end
        end
        ccrc_pkg::TW2_SHIFT: begin
          if (tw2_fall) begin
            tw2_shift <= {tw2_dat_s, tw2_shift[ccrc_pkg::TW2_BITS-1:1]};
            tw2_cnt   <= tw2_cnt + 4'h1;
            if (tw2_cnt == ccrc_pkg::TW2_LAST) begin
              tw2_state <= ccrc_pkg::TW2_APPLY;
            end
          end
        end
        ccrc_pkg::TW2_APPLY: begin
          if (tw2_rise) begin
            tw2_state <= ccrc_pkg::TW2_IDLE;
          end
        end
        default: begin
          tw2_state <= ccrc_pkg::TW2_IDLE;
        end
      endcase
    end
  end

  logic       tw2_apply;
  logic       tw2_cmd;
  logic [7:0] tw2_byte;
  assign tw2_apply = (tw2_state == ccrc_pkg::TW2_APPLY) & tw2_rise;
  assign tw2_cmd   = tw2_shift[ccrc_pkg::TW2_CMD_BIT];
  assign tw2_byte  = tw2_shift[ccrc_pkg::TW2_DATA_LSB +: 8];

  // Command byte loads the address pointer, data bytes advance it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !pdn_s) begin
      tw2_ptr <= 5'h00;
    end else if (tw2_apply && tw2_cmd) begin
      tw2_ptr <= tw2_byte[4:0];
    end else if (tw2_apply) begin
      tw2_ptr <= tw2_ptr + 5'h01;
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  logic                                wr_req;
  logic                                wr_ok;
  logic [4:0]                          wr_addr;
  logic [7:0]                          wr_data;
  logic [ccrc_pkg::NUM_REGS-1:0][7:0]  regs;

  assign wr_req  = tw3_wr | (tw2_apply & ~tw2_cmd);
  assign wr_addr = mode2_s ? tw2_ptr : tw3_addr;
  assign wr_data = mode2_s ? tw2_byte : tw3_data;
  assign wr_ok   = wr_req & pdn_s & (wr_addr <= ccrc_pkg::ADDR_OUTPUT_GAIN);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !pdn_s) begin
      regs <= ccrc_pkg::REG_RESET;
    end else begin
      for (int r = 0; r < ccrc_pkg::NUM_REGS; r++) begin
        if (wr_ok && wr_addr == 5'(r)) begin
          regs[r] <= wr_data & ccrc_pkg::REG_MASK[r];
        end
      end
    end
  end

  assign o_ctrl = {regs[ccrc_pkg::ADDR_INPUT_SELECTION][3:0],
                   regs[ccrc_pkg::ADDR_BLOCK_POWER_CONTROL][3:0],
                   regs[ccrc_pkg::ADDR_MIXING_FILTER_FORMAT]};

  // ****************************************************
  // Calibration sequencer
  // ****************************************************
  logic [12:0] cal_cnt;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !pdn_s) begin
      o_calibrating <= 1'b0;
      o_cal_valid   <= 1'b0;
      cal_cnt       <= 13'h0000;
    end else if (pdn_rise) begin
      o_calibrating <= 1'b1;
      cal_cnt       <= 13'h0000;
    end else if (o_calibrating && frame_rise) begin
      if (cal_cnt == CAL_LAST) begin
        o_calibrating <= 1'b0;
        o_cal_valid   <= 1'b1;
      end else begin
        cal_cnt <= cal_cnt + 13'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_device_powerdown <= 1'b1;
      o_adc_force_zero   <= 1'b1;
    end else begin
      o_device_powerdown <= ~pdn_s | (o_ctrl[11:8] == ccrc_pkg::POWER_ALL_OFF);
      o_adc_force_zero   <= o_calibrating | ~pdn_s | ~o_ctrl.adc_power;
    end
  end

  // ****************************************************
  // Gain update per channel
  // ****************************************************
  logic [1:0]  gain_wr_d;
  logic [11:0] tmo_limit;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gain_wr_d <= 2'b00;
    end else begin
      gain_wr_d[0] <= wr_ok & (wr_addr == ccrc_pkg::ADDR_INPUT_GAIN);
      gain_wr_d[1] <= wr_ok & (wr_addr == ccrc_pkg::ADDR_OUTPUT_GAIN);
    end
  end

  assign tmo_limit = ccrc_pkg::TIMEOUT_BASE << o_ctrl.zero_cross_timeout;

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    localparam int unsigned REG = ch / 2 + 3;
    logic        pend;
    logic [11:0] tmo_cnt;
    logic        ze;
    logic [6:0]  target;
    logic        tmo_hit;
    assign ze      = regs[REG][ccrc_pkg::ZC_ENABLE_BIT];
    assign target  = regs[REG][6:0];
    assign tmo_hit = frame_rise & (tmo_cnt == tmo_limit - 12'h001);

    always_ff @(posedge i_clk_sys) begin
      if (i_rst || !pdn_s) begin
        o_gain.code[ch] <= 7'h00;
        pend            <= 1'b0;
        tmo_cnt         <= 12'h000;
      end else if (o_calibrating) begin
        o_gain.code[ch] <= 7'h00;
        pend            <= 1'b1;
        tmo_cnt         <= 12'h000;
      end else if (gain_wr_d[ch/2]) begin
        pend    <= 1'b1;
        tmo_cnt <= 12'h000;
      end else if (pend && (!ze || zc_s[ch] || tmo_hit)) begin
        o_gain.code[ch] <= target;
        pend            <= 1'b0;
      end else if (pend && frame_rise) begin
        tmo_cnt <= tmo_cnt + 12'h001;
      end
    end

    a_gain_timeout: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      pdn_s && !o_calibrating && !gain_wr_d[ch/2] && pend && tmo_hit
      |=> o_gain.code[ch] == $past(target))
      else $error("gain not applied at timeout");
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_pdn_defaults: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !pdn_s |=> regs == ccrc_pkg::REG_RESET)
    else $error("registers not at defaults during power-down");

  a_pdn_no_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !pdn_s ##1 !pdn_s |-> !wr_ok ##1 $stable(regs))
    else $error("write accepted during power-down");

  a_cal_start: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pdn_rise |=> o_calibrating && cal_cnt == 13'h0000)
    else $error("calibration did not start on pin rise");

  a_cal_end: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pdn_s && !pdn_rise && o_calibrating && frame_rise && cal_cnt == CAL_LAST
    |=> !o_calibrating && o_cal_valid)
    else $error("calibration length wrong");

  a_cal_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pdn_s && o_calibrating && !frame_rise |=> o_calibrating && $stable(cal_cnt))
    else $error("calibration advanced without frame edge");

  a_adc_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_calibrating |=> o_adc_force_zero)
    else $error("adc words not forced to zero in calibration");

  a_gain_mute: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_calibrating ##1 o_calibrating |-> o_gain.code == '0)
    else $error("gain not muted in calibration");

  a_cal_keep: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_cal_valid && pdn_s ##1 pdn_s |-> o_cal_valid)
    else $error("calibration result lost");

  a_addr_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pdn_s && wr_req && wr_addr > ccrc_pkg::ADDR_OUTPUT_GAIN |=> $stable(regs))
    else $error("write to unmapped address changed a register");

  a_upper_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    regs[0][7:4] == 4'h0 && regs[1][7:4] == 4'h0)
    else $error("unused upper bits not zero");

  a_whole_pd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!pdn_s || o_ctrl[11:8] == 4'h0) |=> o_device_powerdown)
    else $error("device not powered down");

  a_tw2_apply: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tw2_apply && !tw2_cmd && pdn_s && tw2_ptr <= 5'h04
    |=> regs[$past(tw2_ptr)] == ($past(tw2_byte) & ccrc_pkg::REG_MASK[$past(tw2_ptr)]))
    else $error("2-wire byte not written");

endmodule // ccrc_regs

// *** test/ccrc_host_model.sv ***
/*
  Host controller model for the codec control bank: drives 3-wire
  frames and 2-wire transfers on request of the bench.
  Assumes the bench calls its tasks one at a time.
*/
module ccrc_host_model (
  output logic o_three_wire_clock,
  output logic o_three_wire_select_low,
  output logic o_three_wire_data,
  output logic o_two_wire_clock,
  output logic o_two_wire_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************
  // Idle levels: clocks stand still between frames
  // ****************************************************
  initial begin
    o_three_wire_clock      = 1'b1;
    o_three_wire_select_low = 1'b1;
    o_three_wire_data       = 1'b0;
    o_two_wire_clock        = 1'b0;
    o_two_wire_data         = 1'b0;
  end

  // ****************************************************
  // 3-wire frame, 32 ns link clock
  // ****************************************************
  task automatic write3(input logic [4:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {data, addr, 3'b101};
    #3 o_three_wire_select_low = 1'b0;
    for (int i = 0; i < 16; i++) begin
      #16 o_three_wire_clock = 1'b0;
      o_three_wire_data = frame[i];
      #16 o_three_wire_clock = 1'b1;
    end
    #16 o_three_wire_select_low = 1'b1;
    o_three_wire_data = ~frame[15];
  endtask

  // ****************************************************
  // 2-wire transfer: start bit, 3 info bits, 8 data bits
  // ****************************************************
  task automatic send2(input logic cmd, input logic [7:0] data);
    logic [11:0] bits;
    bits = {data, 2'b00, cmd, 1'b1};
    for (int i = 0; i < 12; i++) begin
      #64 o_two_wire_clock = 1'b1;
      o_two_wire_data = bits[i];
      #64 o_two_wire_clock = 1'b0;
    end
    #64 o_two_wire_clock = 1'b1;
    o_two_wire_data = 1'b0;
    #64 o_two_wire_clock = 1'b0;
    #64 o_two_wire_data = 1'b1;
  endtask
endmodule // ccrc_host_model

// *** test/ccrc_regs_tb.sv ***
/*
  Self-checking bench of the codec control bank.
  Assumes the host model on the serial pins and a free frame clock.
*/
module ccrc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                    clk;
  logic                    rst;
  logic                    pin_n;
  logic                    frame_clk;
  logic                    two_mode;
  logic [3:0]              zc;
  logic                    c3;
  logic                    s3;
  logic                    d3;
  logic                    c2;
  logic                    d2;
  ccrc_pkg::ccrc_ctrl_type o_ctrl;
  ccrc_pkg::ccrc_gain_type o_gain;
  logic                    o_calibrating;
  logic                    o_cal_valid;
  logic                    o_adc_force_zero;
  logic                    o_device_powerdown;
  int                      num_errors = 0;
  int                      compares = 0;
  int                      cyc_cnt = 0;

  ccrc_regs #(.CAL_FRAMES(8)) i_ccrc_regs (
    .i_clk_sys(clk), .i_rst(rst), .i_chip_powerdown_pin_n(pin_n),
    .i_frame_clock(frame_clk), .i_two_wire_mode(two_mode),
    .i_three_wire_clock(c3), .i_three_wire_select_low(s3),
    .i_three_wire_data(d3), .i_two_wire_clock(c2), .i_two_wire_data(d2),
    .i_zero_cross(zc), .o_ctrl(o_ctrl), .o_gain(o_gain),
    .o_calibrating(o_calibrating), .o_cal_valid(o_cal_valid),
    .o_adc_force_zero(o_adc_force_zero), .o_device_powerdown(o_device_powerdown));

  ccrc_host_model i_ccrc_host_model (
    .o_three_wire_clock(c3), .o_three_wire_select_low(s3),
    .o_three_wire_data(d3), .o_two_wire_clock(c2), .o_two_wire_data(d2));

  // ****************************************************
  // Clocks and helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    frame_clk = 1'b0;
    forever #100 frame_clk = ~frame_clk;
  end

  always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic w3(input logic [4:0] a, input logic [7:0] d);
    i_ccrc_host_model.write3(a, d);
    cyc(8);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_defaults();
    chk("ctrl", 32'h5f34, 32'(o_ctrl));
    chk("gain", 32'h0, 32'(o_gain));
    chk("powerdown", 32'h1, 32'(o_device_powerdown));
    w3(5'h00, 8'hff);
    chk("ctrl_locked", 32'h5f34, 32'(o_ctrl));
    $display("test defaults done");
  endtask

  task automatic t_cal();
    int t0;
    pin_n = 1'b1;
    for (int n = 0; n < 20 && o_calibrating !== 1'b1; n++) cyc(1);
    t0 = cyc_cnt;
    chk("calibrating", 32'h1, 32'(o_calibrating));
    w3(5'h03, 8'h28);
    chk("gain_muted", 32'h0, 32'(o_gain));
    chk("force_zero", 32'h1, 32'(o_adc_force_zero));
    chk("cal_valid", 32'h0, 32'(o_cal_valid));
    for (int n = 0; n < 2000 && o_calibrating === 1'b1; n++) cyc(1);
    chk("cal_len", 32'h1, 32'((cyc_cnt - t0) >= 280 && (cyc_cnt - t0) <= 330));
    cyc(4);
    chk("cal_valid", 32'h1, 32'(o_cal_valid));
    chk("force_zero", 32'h0, 32'(o_adc_force_zero));
    chk("gain", 32'({7'h00, 7'h00, 7'h28, 7'h28}), 32'(o_gain));
    $display("test calibration done");
  endtask

  task automatic t_fields();
    logic [7:0] v [4] = '{8'h55, 8'haa, 8'hff, 8'h00};
    w3(5'h00, 8'hfa);
    chk("ctrl", 32'haf34, 32'(o_ctrl));
    foreach (v[i]) begin
      w3(5'h02, v[i]);
      chk("ctrl", 32'({8'haf, v[i]}), 32'(o_ctrl));
    end
    w3(5'h05, 8'h77);
    w3(5'h13, 8'h00);
    chk("out_gain_kept", 32'h0, 32'({o_gain.code[3], o_gain.code[2]}));
    chk("ctrl_kept", 32'haf00, 32'(o_ctrl));
    chk("gain_kept", 32'h28, 32'(o_gain.code[0]));
    $display("test fields done");
  endtask

  task automatic t_power();
    w3(5'h01, 8'hf0);
    chk("powerdown", 32'h1, 32'(o_device_powerdown));
    chk("ctrl_kept", 32'ha000, 32'(o_ctrl));
    chk("cal_valid", 32'h1, 32'(o_cal_valid));
    w3(5'h01, 8'h0d);
    chk("powerdown", 32'h0, 32'(o_device_powerdown));
    chk("force_zero", 32'h1, 32'(o_adc_force_zero));
    w3(5'h01, 8'h0f);
    chk("force_zero", 32'h0, 32'(o_adc_force_zero));
    chk("no_recal", 32'h0, 32'(o_calibrating));
    $display("test power done");
  endtask

  task automatic t_two_wire();
    two_mode = 1'b1;
    cyc(4);
    i_ccrc_host_model.send2(1'b1, 8'h03);
    i_ccrc_host_model.send2(1'b0, 8'h30);
    i_ccrc_host_model.send2(1'b0, 8'h25);
    cyc(8);
    chk("gain", 32'({7'h25, 7'h25, 7'h30, 7'h30}), 32'(o_gain));
    two_mode = 1'b0;
    cyc(4);
    $display("test two wire done");
  endtask

  task automatic t_zero_cross();
    int n;
    w3(5'h03, 8'hc0);
    cyc(20);
    chk("gain_held", 32'h30, 32'(o_gain.code[0]));
    zc = 4'h1;
    cyc(6);
    zc = 4'h0;
    chk("gain_left", 32'h40, 32'(o_gain.code[0]));
    chk("gain_right", 32'h30, 32'(o_gain.code[1]));
    for (n = 0; n < 12000 && o_gain.code[1] !== 7'h40; n++) cyc(1);
    chk("timeout_len", 32'h1, 32'(n >= 9900 && n <= 10300));
    $display("test zero cross done");
  endtask

  task automatic t_pin_low();
    pin_n = 1'b0;
    cyc(6);
    chk("ctrl", 32'h5f34, 32'(o_ctrl));
    chk("powerdown", 32'h1, 32'(o_device_powerdown));
    w3(5'h02, 8'hff);
    chk("ctrl_locked", 32'h5f34, 32'(o_ctrl));
    pin_n = 1'b1;
    cyc(6);
    chk("calibrating", 32'h1, 32'(o_calibrating));
    $display("test pin low done");
  endtask

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    rst = 1'b1;
    pin_n = 1'b0;
    two_mode = 1'b0;
    zc = 4'h0;
    cyc(8);
    rst = 1'b0;
    cyc(4);
    t_defaults();
    t_cal();
    t_fields();
    t_power();
    t_two_wire();
    t_zero_cross();
    t_pin_low();
    test_done();
  end

  initial begin
    #300us;
    num_errors++;
    $display("[ERR] watchdog expected done seen hang");
    test_done();
  end
endmodule // ccrc_regs_tb
